//--- design/port_power_indicator_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - one switch output and sense input per port
// - ganged or per-port power and sensing
// - sense must persist beyond filter, then trip
// - active-low switch enable drives port power
// - port status changes reported via interrupt
// - green and amber output per port
// - automatic and manual modes, automatic at reset
// - auto amber on overload, otherwise off states
// - auto green when enabled or transmitting
// - host commands manual indicator state, held
// - manual off, amber, green, blink green, blink amber
// - indicators selectable, absent reported when off
// - config bit 2 selects ganged sensing
// - config bit 1 selects ganged switching
// - config bit 6 says indicators present
module port_power_indicator_ctrl
   import port_ctrl_pkg::*;
#(
   parameter int PORTS      = PORT_COUNT,
   parameter int BLINK_HALF = BLINK_HALF_CYC
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // register port
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [15:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [15:0]       reg_rdata_o,
   // hub port state, three bits per port
   input  wire logic [3*PORTS-1:0] port_state_i,
   // external power switches and monitors
   input  wire logic [PORTS-1:0]  port_overload_in_n,
   output logic      [PORTS-1:0]  port_power_switch_n,
   // indicators
   output logic      [PORTS-1:0]  led_green_o,
   output logic      [PORTS-1:0]  led_amber_o,
   // status change interrupt
   output logic                   irq_o
);
   // refuse port counts that the register fields cannot hold
   if (PORTS < 1 || PORTS > 4) begin : g_bad_ports
      $error("ports must be 1 to 4");
   end

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0]        config_r;   // arrangement and mode bits
      logic [15:0]        filter;     // over-current filter count
      logic [PORTS-1:0]   power_on;   // host power request per port
      logic [3*PORTS-1:0] manual;     // manual led codes
      logic [PORTS-1:0]   status;     // sticky change events
      logic [PORTS-1:0]   mask;       // event enable
      logic [PORTS-1:0]   fault_prev; // for change detection
      logic [PORTS-1:0]   switch_n;   // switch outputs
      logic [PORTS-1:0]   green;      // green outputs
      logic [PORTS-1:0]   amber;      // amber outputs
      logic [15:0]        rdata;      // read data register
   } ctrl_state_type;

   ctrl_state_type st_q;   // registered state
   ctrl_state_type st_d;   // next state

   reg_req_type    req;    // bundled bus request
   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                  wr: reg_wr_i, rd: reg_rd_i};

   // ---------------------------------------------------------------
   // over-current filtering
   // ---------------------------------------------------------------
   logic [PORTS-1:0] raw_fault;    // filtered per input
   logic [PORTS-1:0] port_fault;   // fault as applied to ports
   logic             gang_sense;   // shared sense selected
   logic             gang_switch;  // shared switch selected
   logic             blink;        // blink phase

   assign gang_sense  = st_q.config_r[CFG_SENSE_GANG];
   assign gang_switch = st_q.config_r[CFG_SWITCH_GANG];

   // one filter per sense input; inputs are active low
   // count restarts on any released sample, so chatter never trips
   generate
      for (genvar p = 0; p < PORTS; p++) begin : g_filt
         overload_filter #(
            .W (FILT_W)
         ) u_filt (
            .clk_i   (clk_i),
            .rstn_i  (rstn_i),
            .sense_i (~port_overload_in_n[p]),
            .limit_i (st_q.filter),
            .fault_o (raw_fault[p])
         );
      end
   endgenerate

   // ganged mode uses the first input for every port
   // the other sense inputs are then ignored
   assign port_fault = gang_sense ? {PORTS{raw_fault[0]}}
                                  : raw_fault;

   blink_timer #(
      .HALF (BLINK_HALF)
   ) u_blink (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .phase_o (blink)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [PORTS-1:0] events;   // newly changed faults
      logic             any_on;   // ganged power request
      logic             any_f;    // any fault present
      port_state_type   ps;       // one port state
      led_cmd_type      cmd;      // one manual code
      events = '0;
      any_on = 1'b0;
      any_f  = 1'b0;
      ps     = PS_DISCONNECTED;
      cmd    = LED_OFF;
      st_d   = st_q;

      // register writes
      if (req.wr) begin
         case (req.addr)
            ADDR_CONFIG:     st_d.config_r = req.wdata;
            ADDR_FILTER:     st_d.filter   = req.wdata;
            ADDR_PORT_CTRL:  st_d.power_on = req.wdata[PORTS-1:0];
            ADDR_LED_MANUAL: st_d.manual   = req.wdata[3*PORTS-1:0];
            ADDR_MASK:       st_d.mask     = req.wdata[PORTS-1:0];
            default: ;
         endcase
      end

      // register reads, data valid next cycle only
      st_d.rdata = '0;
      if (req.rd) begin
         case (req.addr)
            ADDR_CONFIG: begin
               st_d.rdata = st_q.config_r;
               // without indicators the present bit reads back low
               st_d.rdata[CFG_IND_PRESENT] =
                  st_q.config_r[CFG_IND_PRESENT];
            end
            ADDR_FILTER:     st_d.rdata = st_q.filter;
            ADDR_PORT_CTRL:  st_d.rdata[PORTS-1:0] = st_q.power_on;
            ADDR_LED_MANUAL: st_d.rdata[3*PORTS-1:0] = st_q.manual;
            ADDR_STATUS:     st_d.rdata[PORTS-1:0] = st_q.status;
            ADDR_MASK:       st_d.rdata[PORTS-1:0] = st_q.mask;
            ADDR_LIVE:       st_d.rdata[PORTS-1:0] = port_fault;
            default:         st_d.rdata = '0;
         endcase
      end

      // change events: a read clears status, new events win
      events = port_fault ^ st_q.fault_prev;
      st_d.fault_prev = port_fault;
      if (req.rd && req.addr == ADDR_STATUS) begin
         st_d.status = '0;
      end
      st_d.status = st_d.status | events;

      // power switch drive, active low
      // a fault beats the request; power returns once sense clears
      any_on = |st_q.power_on;
      any_f  = |port_fault;
      for (int p = 0; p < PORTS; p++) begin
         if (gang_switch) begin
            st_d.switch_n[p] = ~(any_on & ~any_f);
         end else begin
            st_d.switch_n[p] = ~(st_q.power_on[p]
                                 & ~port_fault[p]);
         end
      end

      // indicators
      // one shared blink phase keeps all blinking lamps in step
      for (int p = 0; p < PORTS; p++) begin
         ps  = port_state_type'(port_state_i[3*p +: 3]);
         cmd = led_cmd_type'(st_q.manual[3*p +: 3]);
         st_d.green[p] = 1'b0;
         st_d.amber[p] = 1'b0;
         if (!st_q.config_r[CFG_IND_PRESENT]) begin
            // no lamps fitted: keep both dark
            st_d.green[p] = 1'b0;
         end else if (!st_q.config_r[CFG_MANUAL_MODE]) begin
            // automatic mode, default after reset
            if (port_fault[p]) begin
               st_d.amber[p] = 1'b1;
            end else begin
               case (ps)
                  PS_ENABLED,
                  PS_TRANSMIT,
                  PS_TRANSMIT_RES: st_d.green[p] = 1'b1;
                  default:         st_d.green[p] = 1'b0;
               endcase
            end
         end else begin
            case (cmd)
               LED_OFF:       st_d.green[p] = 1'b0;
               LED_AMBER:     st_d.amber[p] = 1'b1;
               LED_GREEN:     st_d.green[p] = 1'b1;
               LED_BLINK_GRN: st_d.green[p] = blink;
               LED_BLINK_AMB: st_d.amber[p] = blink;
               default:       st_d.green[p] = 1'b0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q          <= '0;
         st_q.config_r <= CONFIG_RESET;
         st_q.filter   <= FILTER_RESET;
         st_q.switch_n <= '1;   // power off until requested
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o         = st_q.rdata;
   assign port_power_switch_n = st_q.switch_n;
   assign led_green_o         = st_q.green;
   assign led_amber_o         = st_q.amber;
   assign irq_o               = |(st_q.status & st_q.mask);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // tripped port loses power next edge
   a_trip_power: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (port_fault[0] && !gang_switch) |=> port_power_switch_n[0])
      else $error("faulted port still powered");

   // shared sense reaches every port at once
   a_gang_trip: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (gang_sense && raw_fault[0]) |-> &port_fault)
      else $error("ganged fault not on all ports");

   // last port shows amber on overload
   a_auto_amber: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (port_fault[PORTS-1] && st_q.config_r[CFG_IND_PRESENT]
       && !st_q.config_r[CFG_MANUAL_MODE]) |=> led_amber_o[PORTS-1])
      else $error("auto amber missing");

   // no lamps fitted, both colours dark
   a_no_lamps: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !st_q.config_r[CFG_IND_PRESENT] |=> (led_green_o == '0
                                           && led_amber_o == '0))
      else $error("lamp lit without indicators");

   // every fault change leaves a sticky bit
   a_event_sticky: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      $changed(port_fault) |=> (st_q.status != '0))
      else $error("change not recorded");

   // status read with no new change empties status
   a_read_clear: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      (reg_rd_i && reg_addr_i == ADDR_STATUS && !$changed(port_fault))
      |=> (st_q.status == '0))
      else $error("status not cleared by read");

   // level interrupt while unmasked status set
   a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_q.status & st_q.mask) != '0 |-> irq_o)
      else $error("irq not raised");

   // requested healthy port is powered next edge
   a_power_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!gang_switch && st_q.power_on[0] && !port_fault[0])
      |=> !port_power_switch_n[0])
      else $error("requested port not powered");

   // ganged enables move as one
   a_gang_switch: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      gang_switch |=> (port_power_switch_n == '0
                       || port_power_switch_n == '1))
      else $error("ganged switches disagree");

   // automatic green for an enabled port
   a_auto_green: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      (st_q.config_r[CFG_IND_PRESENT] && !st_q.config_r[CFG_MANUAL_MODE]
       && !port_fault[0] && port_state_i[2:0] == PS_ENABLED)
      |=> led_green_o[0])
      else $error("auto green missing");

   // commanded green is held
   a_manual_green: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      (st_q.config_r[CFG_MANUAL_MODE] && st_q.config_r[CFG_IND_PRESENT]
       && st_q.manual[2:0] == LED_GREEN) |=> led_green_o[0])
      else $error("manual green missing");

   // blinking amber follows the phase one edge later
   a_blink_amber: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      (st_q.config_r[CFG_MANUAL_MODE] && st_q.config_r[CFG_IND_PRESENT]
       && st_q.manual[3*(PORTS-1) +: 3] == LED_BLINK_AMB)
      |=> (led_amber_o[PORTS-1] == $past(blink)))
      else $error("blink amber off phase");

   // config reads back one cycle later
   a_read_latency: assert property (@(posedge clk_i)
      disable iff (!rstn_i)
      (reg_rd_i && reg_addr_i == ADDR_CONFIG) |=>
         reg_rdata_o == $past(st_q.config_r))
      else $error("config read mismatch");

   // ---------------------------------------------------------------
   // scenario covers
   // ---------------------------------------------------------------
   c_trip: cover property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(port_fault[0]));

   c_blink: cover property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(led_green_o[PORTS-1]) && st_q.config_r[CFG_MANUAL_MODE]);

   c_irq: cover property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(irq_o));

   c_gang: cover property (@(posedge clk_i) disable iff (!rstn_i)
      gang_sense && $rose(raw_fault[0]));
endmodule // port_power_indicator_ctrl

//--- design/port_ctrl_pkg.sv
package port_ctrl_pkg;
   // ---------------------------------------------------------------
   // port count and timing
   // ---------------------------------------------------------------
   localparam int          PORT_COUNT      = 4;   // downstream ports
   localparam int          CLK_HZ          = 20_000_000; // core clock
   localparam int          BLINK_HALF_MS   = 250; // half blink period
   // cycles per blink half period, rounded down (shortest time)
   localparam int          BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int          FILT_W          = 16;  // filter count width

   // ---------------------------------------------------------------
   // configuration register layout and offsets
   // ---------------------------------------------------------------
   localparam logic [3:0]  ADDR_CONFIG     = 4'h0; // configuration
   localparam logic [3:0]  ADDR_FILTER     = 4'h1; // filter count
   localparam logic [3:0]  ADDR_PORT_CTRL  = 4'h2; // per port control
   localparam logic [3:0]  ADDR_LED_MANUAL = 4'h3; // manual led codes
   localparam logic [3:0]  ADDR_STATUS     = 4'h4; // sticky events
   localparam logic [3:0]  ADDR_MASK       = 4'h5; // event mask
   localparam logic [3:0]  ADDR_LIVE       = 4'h6; // live port faults
   localparam int          CFG_SENSE_GANG  = 2;   // sensing arrangement
   localparam int          CFG_SWITCH_GANG = 1;   // switching arrangement
   localparam int          CFG_IND_PRESENT = 6;   // indicators present
   localparam int          CFG_MANUAL_MODE = 8;   // manual indicator mode
   localparam logic [15:0] CONFIG_RESET    = 16'h0000;
   localparam logic [15:0] FILTER_RESET    = 16'h0000;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   // manual indicator commands
   typedef enum logic [2:0] {
      LED_OFF        = 3'b000,
      LED_AMBER      = 3'b001,
      LED_GREEN      = 3'b010,
      LED_BLINK_GRN  = 3'b011,
      LED_BLINK_AMB  = 3'b100
   } led_cmd_type;

   // hub-side port state as seen by the indicator logic
   typedef enum logic [2:0] {
      PS_DISCONNECTED = 3'b000,
      PS_DISABLED     = 3'b001,
      PS_ENABLED      = 3'b010,
      PS_TRANSMIT     = 3'b011,
      PS_TRANSMIT_RES = 3'b100,
      PS_OTHER_QUIET  = 3'b101
   } port_state_type;

   // register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   // lamp pair per port
   typedef struct packed {
      logic green;
      logic amber;
   } lamp_type;
endpackage : port_ctrl_pkg

//--- design/overload_filter.sv
`timescale 1ns/100ps
// one-port debounce: flags once input held longer than the limit
module overload_filter
   import port_ctrl_pkg::*;
#(
   parameter int W = FILT_W
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   // sense and limit
   input  wire logic         sense_i,   // asserted high here
   input  wire logic [W-1:0] limit_i,   // filter count
   // result
   output logic              fault_o    // held condition
);
   if (W < 2) begin : g_bad_width
      $error("filter width too small");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         fault;
   } filt_state_type;

   filt_state_type st_q;   // registered state
   filt_state_type st_d;   // next state

   // count while asserted; fault only past the limit
   always_comb begin
      st_d = st_q;
      if (!sense_i) begin
         // glitch shorter than the limit is forgotten
         st_d.cnt   = '0;
         st_d.fault = 1'b0;
      end else if (st_q.cnt > limit_i) begin
         st_d.fault = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + W'(1);
      end
   end

   // register the state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fault_o = st_q.fault;

   a_filter_glitch: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !sense_i |=> !fault_o) else $error("fault without sense");
endmodule // overload_filter

//--- design/blink_timer.sv
`timescale 1ns/100ps
// free running square wave for blinking indicators
module blink_timer
   import port_ctrl_pkg::*;
#(
   parameter int HALF = BLINK_HALF_CYC
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // phase output
   output logic      phase_o    // high half of blink
);
   if (HALF < 1) begin : g_bad_half
      $error("blink half period too short");
   end

   localparam int CW = $clog2(HALF + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          phase;
   } blink_state_type;

   blink_state_type st_q;   // registered state
   blink_state_type st_d;   // next state

   // equal on and off halves
   always_comb begin
      st_d = st_q;
      if (st_q.cnt == CW'(HALF - 1)) begin
         st_d.cnt   = '0;
         st_d.phase = ~st_q.phase;
      end else begin
         st_d.cnt = st_q.cnt + CW'(1);
      end
   end

   // register the state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign phase_o = st_q.phase;
endmodule // blink_timer

//--- bench/overload_monitor.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// external over-current monitors and power switches
// ---------------------------------------------------------------
module overload_monitor
   import port_ctrl_pkg::*;
(
   // scenario control
   input  wire logic [PORT_COUNT-1:0] trip_i,       // force an overload
   // switch enables from the hub
   input  wire logic [PORT_COUNT-1:0] switch_n_i,   // active low enable
   // sense lines back to the hub
   output logic      [PORT_COUNT-1:0] overload_n_o, // active low sense
   output logic      [PORT_COUNT-1:0] powered_o     // port has power
);
   // the sense line rests high through its pull-up and is pulled
   // low only while a trip is forced, one line per port
   assign overload_n_o = ~trip_i;
   // switch conducts while its enable is low
   assign powered_o = ~switch_n_i;
endmodule // overload_monitor

//--- bench/tb_port_power_indicator_ctrl.sv
`timescale 1ns/100ps
module tb_port_power_indicator_ctrl;
   import port_ctrl_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int   HALF = 4;          // short blink half period
   localparam int   FILT = 6;          // filter count under test
   logic            clk_i;             // core clock
   logic            rstn_i;            // sync reset, active low
   logic [3:0]      reg_addr_i;        // register address
   logic [15:0]     reg_wdata_i;       // write data
   logic            reg_wr_i;          // write strobe
   logic            reg_rd_i;          // read strobe
   logic [15:0]     reg_rdata_o;       // read data
   logic [11:0]     port_state_i;      // hub port states
   logic [3:0]      ovl_n;             // sense lines
   logic [3:0]      sw_n;              // switch enables
   logic [3:0]      pwr;               // monitor view of power
   logic [3:0]      grn;               // green lamps
   logic [3:0]      amb;               // amber lamps
   logic            irq_o;             // status change interrupt
   logic [3:0]      trip;              // forced overloads
   logic [15:0]     d;                 // read result
   int              c;                 // blink count
   int              n_mismatch;        // mismatches seen
   int              cmp_count;         // comparisons made

   // ------------------------------------------------------------
   // clock, design and partner
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   port_power_indicator_ctrl #(.PORTS(PORT_COUNT), .BLINK_HALF(HALF)) DUT (
      .clk_i               (clk_i),
      .rstn_i              (rstn_i),
      .reg_addr_i          (reg_addr_i),
      .reg_wdata_i         (reg_wdata_i),
      .reg_wr_i            (reg_wr_i),
      .reg_rd_i            (reg_rd_i),
      .reg_rdata_o         (reg_rdata_o),
      .port_state_i        (port_state_i),
      .port_overload_in_n  (ovl_n),
      .port_power_switch_n (sw_n),
      .led_green_o         (grn),
      .led_amber_o         (amb),
      .irq_o               (irq_o)
   );

   overload_monitor mon (
      .trip_i       (trip),
      .switch_n_i   (sw_n),
      .overload_n_o (ovl_n),
      .powered_o    (pwr)
   );

   // ------------------------------------------------------------
   // bus tasks and checks
   // ------------------------------------------------------------
   // one-cycle write strobe, released right after the taking edge
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   // counts lit samples of port 3 over two blink periods
   task automatic count_lit(input bit use_amber, output int n);
      n = 0;
      repeat (4 * HALF) begin
         @(posedge clk_i);
         #1 n += use_amber ? int'(amb[3]) : int'(grn[3]);
      end
   endtask

   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // a hang costs a mismatch; the tests need well under 2000 cycles
   initial begin
      #(50 * 20000);
      n_mismatch++;
      end_sim;
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      rstn_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 16'h0000;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      port_state_i = 12'h000;
      trip = 4'h0;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1;
      // reset state: switches off, lamps dark, auto mode
      chk({12'h000, sw_n}, 16'h000f);
      chk({8'h00, grn, amb}, 16'h0000);
      chk({15'h0000, irq_o}, 16'h0000);
      // every register clears; address 7 is unmapped
      for (int a = 0; a < 8; a++) begin
         rd_reg(a[3:0], d);
         chk(d, 16'h0000);
      end
      // per-port switching, then ganged switching
      wr_reg(ADDR_PORT_CTRL, 16'h0005);
      idle(2);
      chk({12'h000, sw_n}, 16'h000a);
      wr_reg(ADDR_CONFIG, 16'h0002);
      idle(2);
      chk({12'h000, sw_n}, 16'h0000);
      wr_reg(ADDR_CONFIG, 16'h0000);
      wr_reg(ADDR_PORT_CTRL, 16'h000f);
      wr_reg(ADDR_FILTER, 16'(FILT));
      wr_reg(ADDR_MASK, 16'h0002);
      // a glitch no longer than the filter is ignored
      @(posedge clk_i);
      trip <= 4'h2;
      repeat (FILT) @(posedge clk_i);
      trip <= 4'h0;
      idle(4);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h000f, 16'h0000);
      chk({12'h000, sw_n}, 16'h0000);
      // a held overload trips only its own port
      @(posedge clk_i);
      trip <= 4'h2;
      idle(FILT);
      chk({12'h000, sw_n}, 16'h0000);
      idle(4);
      chk({12'h000, sw_n}, 16'h0002);
      chk({12'h000, pwr}, 16'h000d);
      chk({15'h0000, irq_o}, 16'h0001);
      rd_reg(ADDR_LIVE, d);
      chk(d & 16'h000f, 16'h0002);
      wr_reg(ADDR_MASK, 16'h0000);
      idle(1);
      chk({15'h0000, irq_o}, 16'h0000);
      wr_reg(ADDR_MASK, 16'h0002);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h000f, 16'h0002);
      idle(1);
      chk({15'h0000, irq_o}, 16'h0000);
      // the end of the overload is a change as well
      @(posedge clk_i);
      trip <= 4'h0;
      idle(4);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h000f, 16'h0002);
      // ganged sensing: input 0 trips every port
      wr_reg(ADDR_CONFIG, 16'h0004);
      @(posedge clk_i);
      trip <= 4'h1;
      idle(FILT + 6);
      chk({12'h000, sw_n}, 16'h000f);
      @(posedge clk_i);
      trip <= 4'h0;
      // automatic lamps from the port states
      port_state_i <= {PS_DISCONNECTED, PS_TRANSMIT_RES, PS_TRANSMIT,
                       PS_ENABLED};
      wr_reg(ADDR_CONFIG, 16'h0040);
      idle(3);
      chk({8'h00, grn, amb}, 16'h0070);
      rd_reg(ADDR_CONFIG, d);
      chk(d, 16'h0040);
      @(posedge clk_i);
      port_state_i <= {PS_ENABLED, PS_DISABLED, PS_OTHER_QUIET,
                       PS_DISCONNECTED};
      trip <= 4'h8;
      idle(FILT + 6);
      chk({8'h00, grn, amb}, 16'h0008);
      // indicators absent leaves every lamp dark
      wr_reg(ADDR_CONFIG, 16'h0000);
      idle(3);
      chk({8'h00, grn, amb}, 16'h0000);
      @(posedge clk_i);
      trip <= 4'h0;
      // manual commands on each port
      wr_reg(ADDR_LED_MANUAL, {4'h0, LED_BLINK_GRN, LED_GREEN, LED_AMBER,
                               LED_OFF});
      wr_reg(ADDR_CONFIG, 16'h0140);
      idle(3);
      chk({8'h00, grn & 4'h7, amb}, 16'h0042);
      count_lit(1'b0, c);
      chk(16'(c), 16'(2 * HALF));
      wr_reg(ADDR_LED_MANUAL, {4'h0, LED_BLINK_AMB, LED_GREEN, LED_AMBER,
                               LED_GREEN});
      idle(2);
      count_lit(1'b1, c);
      chk(16'(c), 16'(2 * HALF));
      chk({12'h000, grn}, 16'h0005);
      end_sim;
   end
endmodule // tb_port_power_indicator_ctrl
